// file: hdl/flash_seq_pkg.sv
/*
 Shared constants and carrier types for the flash self-programming sequencer.
 Assumes a single system clock; the flash array itself is modelled by the
 sequencer's own storage and is reached only through the ports declared here.
*/
package flash_seq_pkg;
    localparam int ROW_INSNS = 64;
    localparam int ROW_BYTES = 192;
    localparam int PAGE_ROWS = 8;
    localparam int PAGE_INSNS = 512;
    localparam int PAGE_BYTES = 1536;
    localparam int ADDR_W = 24;
    localparam int PC_W = 23;
    localparam int INSN_W = 24;
    localparam logic [23:0] USER_TOP = 24'h7fffff;
    localparam logic [23:0] CFG_BASE = 24'hf80000;
    localparam logic [23:0] CFG_LAST = 24'hf80017;
    localparam logic [23:0] ID_BASE = 24'hff0000;
    localparam logic [23:0] ID_LAST = 24'hff0003;
    localparam int TABLE_PAGE_REG_CFG_BIT = 7;
    localparam int CTRL_START_BIT = 15;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // Oscillator cycles per operation; table write length in system clocks
    localparam int ROW_WRITE_OSC = 11064;
    localparam int WORD_WRITE_OSC = 355;
    localparam int PAGE_ERASE_OSC = 168517;
    localparam int TBLWT_CYCLES = 2;
    // Control register operation field, low bits
    localparam logic [1:0] OP_WORD = 2'h1;
    localparam logic [1:0] OP_ROW = 2'h2;
    localparam logic [1:0] OP_PAGE = 2'h3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    typedef struct packed {
        logic wr_low;
        logic wr_high;
        logic rd;
        logic [15:0] offset;
        logic [15:0] wdata;
    } table_req_s;
endpackage

// file: hdl/rc_osc_tick.sv
/*
 Internal RC oscillator tick source: a tunable phase accumulator producing
 one tick per oscillator period. Assumes the tune word comes from the core.
*/
`timescale 1ns/100ps
module rc_osc_tick import flash_seq_pkg::*; #(
    parameter int ACC_W = 16,
    parameter logic [15:0] BASE_INC = 16'h12de
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [5:0] tune,
    output logic tick
);
    logic [ACC_W:0] acc;
    logic [ACC_W-1:0] inc;

    // Tuning trims the nominal rate, so times scale with it
    assign inc = BASE_INC + {{(ACC_W-6){tune[5]}}, tune};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= {1'b0, acc[ACC_W-1:0]} + {1'b0, inc};
            tick <= acc[ACC_W];
        end
    end
endmodule

// file: hdl/flash_self_programming_seq.sv
/*
 Flash self-programming sequencer: holding buffers, key unlock, control
 register, timed row/word/page operations, CPU stall and table read path.
 Assumes the CPU presents one table request per cycle and honours cpu_stall.
*/
`timescale 1ns/100ps
module flash_self_programming_seq import flash_seq_pkg::*; #(
    parameter int FLASH_INSNS = 22016,
    parameter int ROW_WRITE_TICKS = ROW_WRITE_OSC,
    parameter int WORD_WRITE_TICKS = WORD_WRITE_OSC,
    parameter int PAGE_ERASE_TICKS = PAGE_ERASE_OSC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire table_req_s table_req,
    input wire logic [7:0] table_page_reg,
    input wire logic [PC_W-1:0] program_counter,
    input wire logic fetch_en,
    input wire logic ctrl_we,
    input wire logic [15:0] ctrl_wdata,
    input wire logic key_we,
    input wire logic [7:0] key_wdata,
    input wire logic [5:0] osc_tune,
    output logic [15:0] nvm_control_reg,
    output logic [INSN_W-1:0] rdata,
    output logic rdata_valid,
    output logic access_fault,
    output logic cpu_stall,
    output logic busy
);
    typedef enum {S_IDLE, S_RUN, S_COMMIT} state_e;
    localparam int ARR_W = $clog2(FLASH_INSNS);
    localparam int TICK_W = 18;

    state_e state;
    logic [INSN_W-1:0] flash_mem [FLASH_INSNS];
    logic [INSN_W-1:0] hold_buf [ROW_INSNS];
    logic [5:0] hold_idx;
    logic [22:0] op_base;
    logic [TICK_W-1:0] tick_cnt;
    logic [9:0] commit_idx;
    logic [9:0] commit_last;
    logic [1:0] key_state;
    logic osc_tick;
    logic tbl_busy;
    logic [ADDR_W-1:0] tbl_addr;
    logic user_ok;
    logic cfg_ok;

    function automatic logic [ADDR_W-1:0] to_insn(input logic [ADDR_W-1:0] a);
        return {1'b0, a[ADDR_W-1:1]};
    endfunction

    rc_osc_tick u_osc (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tune(osc_tune),
        .tick(osc_tick)
    );

    // Table address formed from page register and offset
    assign tbl_addr = {table_page_reg, table_req.offset};
    assign user_ok = tbl_addr <= USER_TOP;
    assign cfg_ok = table_page_reg[TABLE_PAGE_REG_CFG_BIT] && ((tbl_addr >= CFG_BASE && tbl_addr <= CFG_LAST) ||
        (tbl_addr >= ID_BASE && tbl_addr <= ID_LAST));

    // Unlock key: 0x55 then 0xAA on consecutive key writes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            key_state <= 2'h0;
        end else if (key_we) begin
            if (key_wdata == KEY_FIRST) begin
                key_state <= 2'h1;
            end else if (key_wdata == KEY_SECOND && key_state == 2'h1) begin
                key_state <= 2'h2;
            end else begin
                key_state <= 2'h0;
            end
        end else if (ctrl_we) begin
            key_state <= 2'h0;
        end
    end

    // Holding buffer fill; writes never touch the array
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hold_idx <= '0;
            tbl_busy <= 1'b0;
        end else begin
            tbl_busy <= (table_req.wr_low || table_req.wr_high) && !tbl_busy && state == S_IDLE;
            if (state == S_COMMIT) begin
                hold_idx <= '0;
            end else if (table_req.wr_high && !tbl_busy && state == S_IDLE) begin
                hold_idx <= hold_idx + 6'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (state == S_IDLE && !tbl_busy) begin
            // Slot from offset so a sequential fill lands in order
            if (table_req.wr_low) begin
                hold_buf[6'(to_insn(tbl_addr) % ROW_INSNS)][15:0] <= table_req.wdata;
            end
            if (table_req.wr_high) begin
                hold_buf[6'(to_insn(tbl_addr) % ROW_INSNS)][23:16] <= table_req.wdata[7:0];
            end
        end
    end

    // Control register, sequencing and timing
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= S_IDLE;
            nvm_control_reg <= CTRL_RESET;
            op_base <= '0;
            tick_cnt <= '0;
            commit_idx <= '0;
            commit_last <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (ctrl_we) begin
                        nvm_control_reg <= ctrl_wdata;
                        nvm_control_reg[CTRL_START_BIT] <= 1'b0;
                        if (ctrl_wdata[CTRL_START_BIT] && key_state == 2'h2 && ctrl_wdata[1:0] != 2'h0) begin
                            nvm_control_reg[CTRL_START_BIT] <= 1'b1;
                            state <= S_RUN;
                            tick_cnt <= '0;
                            commit_idx <= '0;
                            if (ctrl_wdata[1:0] == OP_PAGE) begin
                                // Page base aligned to 1536 bytes
                                op_base <= 23'((to_insn(tbl_addr) / PAGE_INSNS) * PAGE_INSNS);
                                commit_last <= 10'(PAGE_INSNS - 1);
                            end else if (ctrl_wdata[1:0] == OP_ROW) begin
                                // Row base aligned to 192 bytes
                                op_base <= 23'((to_insn(tbl_addr) / ROW_INSNS) * ROW_INSNS);
                                commit_last <= 10'(ROW_INSNS - 1);
                            end else begin
                                op_base <= 23'(to_insn(tbl_addr));
                                commit_last <= 10'h0;
                            end
                        end
                    end
                end
                S_RUN: begin
                    // Timed in oscillator ticks, not system clocks
                    if (osc_tick) begin
                        tick_cnt <= tick_cnt + 18'h1;
                        if ((nvm_control_reg[1:0] == OP_PAGE && tick_cnt == 18'(PAGE_ERASE_TICKS - 1)) ||
                            (nvm_control_reg[1:0] == OP_ROW && tick_cnt == 18'(ROW_WRITE_TICKS - 1)) ||
                            (nvm_control_reg[1:0] == OP_WORD && tick_cnt == 18'(WORD_WRITE_TICKS - 1))) begin
                            state <= S_COMMIT;
                        end
                    end
                end
                S_COMMIT: begin
                    commit_idx <= commit_idx + 10'h1;
                    if (commit_idx == commit_last) begin
                        state <= S_IDLE;
                        nvm_control_reg[CTRL_START_BIT] <= 1'b0;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Array update, one word per cycle at the end of the timed phase
    always_ff @(posedge clk_sys) begin
        if (state == S_COMMIT && 32'(op_base) + 32'(commit_idx) < FLASH_INSNS) begin
            if (nvm_control_reg[1:0] == OP_PAGE) begin
                flash_mem[ARR_W'(op_base + 23'(commit_idx))] <= '1;
            end else if (nvm_control_reg[1:0] == OP_ROW) begin
                flash_mem[ARR_W'(op_base + 23'(commit_idx))] <= hold_buf[commit_idx[5:0]];
            end else begin
                flash_mem[ARR_W'(op_base)] <= hold_buf[op_base[5:0]];
            end
        end
    end

    // Stall held for the whole operation and table-write second cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cpu_stall <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= state != S_IDLE || (ctrl_we && ctrl_wdata[CTRL_START_BIT] && key_state == 2'h2 &&
                ctrl_wdata[1:0] != 2'h0);
            cpu_stall <= (state == S_RUN) || (state == S_COMMIT && commit_idx != commit_last) ||
                (state == S_IDLE && ctrl_we && ctrl_wdata[CTRL_START_BIT] && key_state == 2'h2 &&
                ctrl_wdata[1:0] != 2'h0) || ((table_req.wr_low || table_req.wr_high) && !tbl_busy &&
                state == S_IDLE);
        end
    end

    // Reads: fetch by counter, table reads by page/offset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
            rdata_valid <= 1'b0;
            access_fault <= 1'b0;
        end else begin
            rdata_valid <= table_req.rd || fetch_en;
            access_fault <= 1'b0;
            rdata <= '0;
            if (fetch_en) begin
                if (32'(program_counter[PC_W-1:1]) < FLASH_INSNS) begin
                    rdata <= flash_mem[ARR_W'(program_counter[PC_W-1:1])];
                end
            end else if (table_req.rd) begin
                if (user_ok) begin
                    if (32'(to_insn(tbl_addr)) < FLASH_INSNS) begin
                        rdata <= flash_mem[ARR_W'(to_insn(tbl_addr))];
                    end // Else zeros
                end else if (!cfg_ok) begin
                    access_fault <= 1'b1;
                end
            end
        end
    end

    a_stall_while_run: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == S_RUN |=> cpu_stall) else $error("cpu not stalled during operation");
    a_start_needs_key: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(nvm_control_reg[CTRL_START_BIT]) |-> $past(key_state) == 2'h2) else $error("start without key");
    a_start_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(nvm_control_reg[CTRL_START_BIT]) |-> state == S_IDLE) else $error("start bit cleared early");
    a_write_two_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
        (table_req.wr_low && state == S_IDLE && !tbl_busy) |=> tbl_busy ##1 !tbl_busy) else $error("table write length");
    a_user_fault: assert property (@(posedge clk_sys) disable iff (!rstn)
        (table_req.rd && !fetch_en && tbl_addr > USER_TOP && !(tbl_addr >= CFG_BASE && tbl_addr <= CFG_LAST) &&
        !(tbl_addr >= ID_BASE && tbl_addr <= ID_LAST)) |=> access_fault)
        else $error("upper half read not refused");
    a_cfg_open: assert property (@(posedge clk_sys) disable iff (!rstn)
        (table_req.rd && !fetch_en && cfg_ok) |=> !access_fault) else $error("config read refused");
    a_row_aligned: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_RUN && nvm_control_reg[1:0] == OP_ROW) |-> op_base % ROW_INSNS == 0)
        else $error("row not aligned");
    a_page_aligned: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_RUN && nvm_control_reg[1:0] == OP_PAGE) |-> op_base % PAGE_INSNS == 0)
        else $error("page not aligned");
    // Fill index must track the slot the offset selects
    a_fill_in_order: assert property (@(posedge clk_sys) disable iff (!rstn)
        (table_req.wr_high && state == S_IDLE && !tbl_busy) |-> 6'(to_insn(tbl_addr)) == hold_idx)
        else $error("holding buffer not filled in order");
    a_busy_start: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(nvm_control_reg[CTRL_START_BIT]) |=> state == S_RUN && busy) else $error("start did not run");
endmodule

// file: testbench/flash_self_programming_seq_tb.sv
/*
 Self-checking bench for the flash self-programming sequencer.
 Assumes shortened operation tick counts and drives every input on falling edges.
*/
`timescale 1ns/100ps
module flash_self_programming_seq_tb import flash_seq_pkg::*;;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    table_req_s rq = '0;
    logic [7:0] tpage = 8'h00;
    logic [PC_W-1:0] pc = '0;
    logic fetch_en = 1'b0;
    logic ctrl_we = 1'b0;
    logic [15:0] ctrl_wdata = 16'h0000;
    logic key_we = 1'b0;
    logic [7:0] key_wdata = 8'h00;
    logic [5:0] osc_tune = 6'h00;
    logic [15:0] nvm_control_reg;
    logic [INSN_W-1:0] rdata;
    logic rdata_valid, access_fault, cpu_stall, busy;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    flash_self_programming_seq #(.ROW_WRITE_TICKS(4), .WORD_WRITE_TICKS(4), .PAGE_ERASE_TICKS(4)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .table_req(rq), .table_page_reg(tpage),
        .program_counter(pc), .fetch_en(fetch_en), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
        .key_we(key_we), .key_wdata(key_wdata), .osc_tune(osc_tune),
        .nvm_control_reg(nvm_control_reg), .rdata(rdata), .rdata_valid(rdata_valid),
        .access_fault(access_fault), .cpu_stall(cpu_stall), .busy(busy));

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Guard against a hang in any bounded wait
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    function automatic logic [23:0] pattern(input int i);
        return 24'h5a0000 + 24'(i * 24'h010203);
    endfunction

    // Low then high table write, each followed by the spacer cycle the stall asks for
    task automatic tbl_wr(input logic [15:0] off, input logic [23:0] d);
        @(negedge clk_sys) rq = {1'b1, 1'b0, 1'b0, off, d[15:0]};
        @(negedge clk_sys) rq = '0;
        chk("write stall", cpu_stall, 1'b1);
        @(negedge clk_sys) rq = {1'b0, 1'b1, 1'b0, off, 8'h00, d[23:16]};
        @(negedge clk_sys) rq = '0;
        @(negedge clk_sys);
    endtask

    task automatic tbl_rd(input logic [7:0] pg, input logic [15:0] off, input logic [23:0] exp, input logic flt);
        @(negedge clk_sys) begin
            tpage = pg;
            rq = {1'b0, 1'b0, 1'b1, off, 16'h0000};
        end
        @(negedge clk_sys) rq = '0;
        repeat (3) begin
            if (rdata_valid === 1'b1 || access_fault === 1'b1)
                break;
            @(negedge clk_sys);
        end
        chk("read fault", access_fault, flt);
        chk("read data", rdata, exp);
        tpage = 8'h00;
    endtask

    // Key pair, optionally broken by a control write, then the start write
    task automatic start_op(input logic [15:0] cw, input bit broken, input bit go);
        @(negedge clk_sys) {key_we, key_wdata} = {1'b1, KEY_FIRST};
        if (broken) begin
            @(negedge clk_sys) {key_we, ctrl_we, ctrl_wdata} = {2'b01, 16'h0002};
            @(negedge clk_sys) {ctrl_we, key_we, key_wdata} = {2'b01, KEY_SECOND};
        end else
            @(negedge clk_sys) key_wdata = KEY_SECOND;
        @(negedge clk_sys) {key_we, ctrl_we, ctrl_wdata} = {2'b01, cw};
        @(negedge clk_sys) ctrl_we = 1'b0;
        repeat (3) begin
            if (busy === 1'b1)
                break;
            @(negedge clk_sys);
        end
        chk("busy", busy, go);
        chk("start bit", nvm_control_reg[CTRL_START_BIT], go);
        chk("stall", cpu_stall, go);
        repeat (3000) begin
            if (busy === 1'b0)
                break;
            @(negedge clk_sys);
        end
        @(negedge clk_sys);
        chk("done busy", busy, 1'b0);
        chk("done start bit", nvm_control_reg[CTRL_START_BIT], 1'b0);
        chk("done stall", cpu_stall, 1'b0);
    endtask

    task automatic t_reset();
        chk("reset ctrl", nvm_control_reg, 24'(CTRL_RESET));
        chk("reset flags", {rdata_valid, access_fault, cpu_stall, busy}, 24'h0);
    endtask

    task automatic t_refused();
        // Valid key but no operation selected: start refused
        start_op(16'h8000, 1'b0, 1'b0);
        // Skipping the key: drop straight into a control write
        @(negedge clk_sys) {ctrl_we, ctrl_wdata} = {1'b1, 16'h8002};
        @(negedge clk_sys) ctrl_we = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("no key busy", busy, 1'b0);
        start_op(16'h8002, 1'b1, 1'b0);
    endtask

    task automatic t_row();
        for (int i = 0; i < ROW_INSNS; i++)
            tbl_wr(16'(2 * i), pattern(i));
        start_op(16'h8002, 1'b0, 1'b1);
        tbl_rd(8'h00, 16'h0000, pattern(0), 1'b0);
        tbl_rd(8'h00, 16'h007e, pattern(63), 1'b0);
        @(negedge clk_sys) {fetch_en, pc} = {1'b1, 23'h000002};
        @(negedge clk_sys) fetch_en = 1'b0;
        repeat (3) begin
            if (rdata_valid === 1'b1)
                break;
            @(negedge clk_sys);
        end
        chk("fetch data", rdata, pattern(1));
    endtask

    task automatic t_word_erase();
        tbl_wr(16'h0080, 24'h13579b);
        // Table pointer names the target word when the start lands
        @(negedge clk_sys) rq.offset = 16'h0080;
        start_op(16'h8001, 1'b0, 1'b1);
        tbl_rd(8'h00, 16'h0080, 24'h13579b, 1'b0);
        tbl_rd(8'h00, 16'h0000, pattern(0), 1'b0);
        osc_tune = 6'h1f;
        start_op(16'h8003, 1'b0, 1'b1);
        osc_tune = 6'h00;
        tbl_rd(8'h00, 16'h0000, 24'hffffff, 1'b0);
        tbl_rd(8'h00, 16'h0080, 24'hffffff, 1'b0);
    endtask

    task automatic t_space();
        tbl_rd(8'h00, 16'hac00, 24'h000000, 1'b0);
        tbl_rd(8'h7f, 16'hfffe, 24'h000000, 1'b0);
        tbl_rd(8'h80, 16'h0000, 24'h000000, 1'b1);
        tbl_rd(8'hf8, 16'h0000, 24'h000000, 1'b0);
        tbl_rd(8'h78, 16'h0000, 24'h000000, 1'b0);
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        t_reset();
        rstn = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_refused();
        t_row();
        t_word_erase();
        t_space();
        test_done();
    end
endmodule
